// >>> lsw_ctrl.sv
/*
 * Four-channel lamp switch control: PWM timebase from an external reference
 * or a calibratable internal divider, clock-fail status, direct input control,
 * wake, toggle timeout and sense source selection.
 * Assumes all control ports come from logic on ref_clk; pins are synchronised.
 */
`include "lsw_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module lsw_ctrl #(
   parameter int unsigned FAIL_LOW_CYC = `LSW_FAIL_LOW_CYC,
   parameter int unsigned CAL_MAX_CYC  = `LSW_CAL_MAX_CYC,
   parameter int unsigned TOGGLE_CYC   = `LSW_TOGGLE_CYC
) (
   input  wire logic                    ref_clk,
   input  wire logic                    nrst,
   input  wire logic                    direct_input_zero,
   input  wire logic                    direct_input_one,
   input  wire logic                    direct_input_two,
   input  wire logic                    direct_input_three,
   input  wire logic                    chip_select_n,
   input  wire logic                    pwm_enable,
   input  wire logic                    clock_source_sel,
   input  wire logic                    fail_safe,
   input  wire logic [3:0]              channel_direct_en,
   input  wire lsw_pkg::lsw_duty_t [3:0] duty_cycle,
   input  wire lsw_pkg::lsw_sense_t     sense_select,
   input  wire logic                    sense_hiz,
   input  wire logic                    clock_fail_clear,
   output logic                         high_side_output_zero,
   output logic                         high_side_output_one,
   output logic                         high_side_output_two,
   output logic                         high_side_output_three,
   output logic                         clock_fail,
   output logic                         calibrated,
   output logic                         wake,
   output logic                         input_toggle_timeout,
   output lsw_pkg::lsw_sense_t          sense_source,
   output logic                         sense_output_en
);
   localparam logic [`LSW_DIV_W-1:0] INT_DIV  = `LSW_DIV_W'(`LSW_INT_TICK_CYC);
   localparam logic [`LSW_DIV_W-1:0] MIN_DIV  = `LSW_DIV_W'(`LSW_MIN_TICK_CYC);
   localparam logic [`LSW_DIV_W-1:0] CAL_MIN  = `LSW_DIV_W'(`LSW_CAL_MIN_CYC);
   localparam logic [`LSW_DIV_W-1:0] CAL_MAX  = `LSW_DIV_W'(CAL_MAX_CYC);
   localparam logic [`LSW_DIV_W-1:0] CAL_OVER = `LSW_DIV_W'(CAL_MAX_CYC + 1);
   localparam logic [`LSW_TOG_W-1:0] TOG_LAST = `LSW_TOG_W'(TOGGLE_CYC - 1);

   logic [3:0]                  din_s1_q;
   logic [3:0]                  din_s2_q;
   logic [3:0]                  din_prev_q;
   logic                        cs_s1_q;
   logic                        cs_s2_q;
   logic                        cs_prev_q;
   logic                        ext_edge;
   logic                        cs_fall;
   logic                        cs_rise;
   logic                        ext_mode;
   lsw_pkg::lsw_cal_state_t     cal_state_q;
   logic [`LSW_DIV_W-1:0]       cs_cnt_q;
   logic                        cal_accept;
   logic [`LSW_DIV_W-1:0]       tick_div_q;
   logic                        cal_ok_q;
   logic [`LSW_DIV_W-1:0]       pre_cnt_q;
   logic                        int_tick;
   logic                        tick;
   logic [7:0]                  pwm_cnt_q;
   logic [3:0]                  hs_q;
   logic                        clock_fail_q;
   logic                        wake_q;
   logic [`LSW_TOG_W-1:0]       tog_cnt_q;
   logic                        tog_timeout_q;
   lsw_pkg::lsw_sense_t         sense_source_q;
   logic                        sense_en_q;
   lsw_clkmon_if                mon_if ();

   // ---------------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ---------------------------------------------------------------------
   // Two flops before any logic; prev copies only the second stage
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         din_s1_q   <= 4'h0;
         din_s2_q   <= 4'h0;
         din_prev_q <= 4'h0;
         cs_s1_q    <= 1'b1;
         cs_s2_q    <= 1'b1;
         cs_prev_q  <= 1'b1;
      end else begin
         din_s1_q   <= {direct_input_three, direct_input_two, direct_input_one, direct_input_zero};
         din_s2_q   <= din_s1_q;
         din_prev_q <= din_s2_q;
         cs_s1_q    <= chip_select_n;
         cs_s2_q    <= cs_s1_q;
         cs_prev_q  <= cs_s2_q;
      end
   end
   assign ext_edge = din_s2_q[0] & ~din_prev_q[0];
   assign cs_fall  = ~cs_s2_q & cs_prev_q;
   assign cs_rise  = cs_s2_q & ~cs_prev_q;
   assign ext_mode = pwm_enable & ~clock_source_sel & ~fail_safe;

   // ---------------------------------------------------------------------
   // Clock-fail monitor and status flag
   // ---------------------------------------------------------------------
   assign mon_if.enable = pwm_enable & ~clock_source_sel;
   assign mon_if.edge_p = ext_edge;

   lsw_clk_monitor #(
      .LOW_CYC (FAIL_LOW_CYC)
   ) u_clk_monitor (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .mon     (mon_if.mon)
   );

   // Sticky; a failure in the clearing cycle wins so none is lost
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         clock_fail_q <= 1'b0;
      end else if (mon_if.fail_p) begin
         clock_fail_q <= 1'b1;
      end else if (clock_fail_clear) begin
         clock_fail_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------------
   // Calibration pulse measurement on chip select
   // ---------------------------------------------------------------------
   // Counter saturates just past the window so long pulses stay rejected
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cal_state_q <= lsw_pkg::LSW_CAL_IDLE;
         cs_cnt_q    <= '0;
      end else begin
         case (cal_state_q)
            lsw_pkg::LSW_CAL_IDLE: begin
               // Fall cycle counts, so the count equals the pulse length and 20 us passes
               if (cs_fall) begin
                  cal_state_q <= lsw_pkg::LSW_CAL_LOW;
                  cs_cnt_q    <= `LSW_DIV_W'(1);
               end
            end
            lsw_pkg::LSW_CAL_LOW: begin
               if (cs_rise) begin
                  cal_state_q <= lsw_pkg::LSW_CAL_IDLE;
               end else if (cs_cnt_q != CAL_OVER) begin
                  cs_cnt_q <= cs_cnt_q + 1'b1;
               end
            end
            default: begin
               cal_state_q <= lsw_pkg::LSW_CAL_IDLE;
            end
         endcase
      end
   end
   assign cal_accept = (cal_state_q == lsw_pkg::LSW_CAL_LOW) & cs_rise &
                       (cs_cnt_q >= CAL_MIN) & (cs_cnt_q <= CAL_MAX);

   // Tick divider: default until calibrated, fail-safe restores default
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         tick_div_q <= INT_DIV;
         cal_ok_q   <= 1'b0;
      end else if (fail_safe) begin
         tick_div_q <= INT_DIV;
         cal_ok_q   <= 1'b0;
      end else if (cal_accept) begin
         tick_div_q <= (cs_cnt_q < MIN_DIV) ? MIN_DIV : cs_cnt_q;
         cal_ok_q   <= 1'b1;
      end
   end

   // ---------------------------------------------------------------------
   // PWM timebase
   // ---------------------------------------------------------------------
   // Compare with >= so a smaller divider loaded mid-count cannot overrun
   assign int_tick = (pre_cnt_q + 1'b1) >= tick_div_q;
   assign tick     = ext_mode ? ext_edge : (pwm_enable & int_tick);
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pre_cnt_q <= '0;
      end else if (!pwm_enable || ext_mode || int_tick) begin
         pre_cnt_q <= '0;
      end else begin
         pre_cnt_q <= pre_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pwm_cnt_q <= 8'h00;
      end else if (!pwm_enable) begin
         pwm_cnt_q <= 8'h00;
      end else if (tick) begin
         pwm_cnt_q <= pwm_cnt_q + 1'b1;
      end
   end

   // ---------------------------------------------------------------------
   // Output channels
   // ---------------------------------------------------------------------
   // Input zero carries the reference in external mode, so it cannot switch
   for (genvar ch = 0; ch < 4; ch++) begin : g_chan
      always_ff @(posedge ref_clk or negedge nrst) begin
         if (!nrst) begin
            hs_q[ch] <= 1'b0;
         end else if (fail_safe) begin
            hs_q[ch] <= din_s2_q[ch];
         end else if (channel_direct_en[ch] && !(ext_mode && ch == 0)) begin
            hs_q[ch] <= din_s2_q[ch];
         end else if (pwm_enable) begin
            hs_q[ch] <= (duty_cycle[ch] == `LSW_DUTY_FULL) ||
                        (pwm_cnt_q < duty_cycle[ch]);
         end else begin
            hs_q[ch] <= 1'b0;
         end
      end
   end
   assign high_side_output_zero  = hs_q[0];
   assign high_side_output_one   = hs_q[1];
   assign high_side_output_two   = hs_q[2];
   assign high_side_output_three = hs_q[3];

   // ---------------------------------------------------------------------
   // Wake and toggle timeout
   // ---------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         wake_q <= 1'b0;
      end else begin
         wake_q <= |din_s2_q;
      end
   end

   // Timeout stays set until the next toggle on any input
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         tog_cnt_q     <= '0;
         tog_timeout_q <= 1'b0;
      end else if (din_s2_q != din_prev_q) begin
         tog_cnt_q     <= '0;
         tog_timeout_q <= 1'b0;
      end else if (tog_cnt_q == TOG_LAST) begin
         tog_timeout_q <= 1'b1;
      end else begin
         tog_cnt_q <= tog_cnt_q + 1'b1;
      end
   end

   // ---------------------------------------------------------------------
   // Sense output selection
   // ---------------------------------------------------------------------
   // Fail-safe reverts to the default: output zero selected, pin released
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sense_source_q <= 3'h0;
         sense_en_q     <= 1'b0;
      end else begin
         sense_source_q <= fail_safe ? 3'h0 : sense_select;
         sense_en_q     <= ~fail_safe & ~sense_hiz;
      end
   end

   assign clock_fail           = clock_fail_q;
   assign calibrated           = cal_ok_q;
   assign wake                 = wake_q;
   assign input_toggle_timeout = tog_timeout_q;
   assign sense_source         = sense_source_q;
   assign sense_output_en      = sense_en_q;

   // ---------------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------------
   property p_fail_flag;
      @(posedge ref_clk) disable iff (!nrst)
      mon_if.fail_p |=> clock_fail_q;
   endproperty
   a_fail_flag: assert property (p_fail_flag) else $error("failure not recorded");

   property p_default_div;
      @(posedge ref_clk) disable iff (!nrst)
      !cal_ok_q |-> tick_div_q == INT_DIV;
   endproperty
   a_default_div: assert property (p_default_div) else $error("uncalibrated divider wrong");

   property p_cal_load;
      @(posedge ref_clk) disable iff (!nrst)
      cal_accept && !fail_safe |=> cal_ok_q && tick_div_q == $past(cs_cnt_q);
   endproperty
   a_cal_load: assert property (p_cal_load) else $error("calibration not taken");

   property p_cal_short;
      @(posedge ref_clk) disable iff (!nrst)
      cs_rise && cs_cnt_q < CAL_MIN && !fail_safe |=> $stable(tick_div_q);
   endproperty
   a_cal_short: assert property (p_cal_short) else $error("short pulse calibrated");

   property p_min_div;
      @(posedge ref_clk) disable iff (!nrst)
      tick_div_q >= MIN_DIV;
   endproperty
   a_min_div: assert property (p_min_div) else $error("PWM rate above limit");

   property p_full_on;
      @(posedge ref_clk) disable iff (!nrst)
      pwm_enable && !fail_safe && !channel_direct_en[1] && duty_cycle[1] == `LSW_DUTY_FULL
      |=> hs_q[1];
   endproperty
   a_full_on: assert property (p_full_on) else $error("full duty not on");

   property p_full_off;
      @(posedge ref_clk) disable iff (!nrst)
      !fail_safe && !channel_direct_en[2] && duty_cycle[2] == 8'h00 |=> !hs_q[2];
   endproperty
   a_full_off: assert property (p_full_off) else $error("zero duty not off");

   property p_direct;
      @(posedge ref_clk) disable iff (!nrst)
      channel_direct_en[3] |=> hs_q[3] == $past(din_s2_q[3]);
   endproperty
   a_direct: assert property (p_direct) else $error("direct input not followed");

   property p_fail_safe;
      @(posedge ref_clk) disable iff (!nrst)
      fail_safe |=> hs_q == $past(din_s2_q) && !sense_en_q;
   endproperty
   a_fail_safe: assert property (p_fail_safe) else $error("fail-safe outputs wrong");

   property p_wake;
      @(posedge ref_clk) disable iff (!nrst)
      (|din_s2_q) |=> wake_q;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake on input");

   property p_toggle;
      @(posedge ref_clk) disable iff (!nrst)
      din_s2_q != din_prev_q |=> !tog_timeout_q && tog_cnt_q == '0;
   endproperty
   a_toggle: assert property (p_toggle) else $error("toggle did not restart timeout");

   property p_hiz;
      @(posedge ref_clk) disable iff (!nrst)
      sense_hiz |=> !sense_en_q;
   endproperty
   a_hiz: assert property (p_hiz) else $error("sense not released");

   property p_sense_sel;
      @(posedge ref_clk) disable iff (!nrst)
      !fail_safe |=> sense_source_q == $past(sense_select);
   endproperty
   a_sense_sel: assert property (p_sense_sel) else $error("sense source not taken");

   c_cal: cover property (@(posedge ref_clk) disable iff (!nrst) cal_accept);
   c_fail: cover property (@(posedge ref_clk) disable iff (!nrst) mon_if.fail_p);
   c_timeout: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(tog_timeout_q));
endmodule
`default_nettype wire

// >>> lsw_cfg.svh
/*
 * Timing and threshold constants for the lamp switch PWM and input control.
 * Assumes a 25 MHz reference clock; every cycle count is derived from it.
 */
`ifndef LSW_CFG_SVH
`define LSW_CFG_SVH

// ----------------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------------
`define LSW_CLK_MHZ         25
`define LSW_CLK_HZ          (`LSW_CLK_MHZ * 1000000)

// ----------------------------------------------------------------------------
// PWM timebase
// ----------------------------------------------------------------------------
`define LSW_PWM_STEPS       256
`define LSW_DUTY_FULL       8'hFF
`define LSW_INT_PWM_HZ      120
`define LSW_INT_TICK_CYC    (`LSW_CLK_HZ / (`LSW_INT_PWM_HZ * `LSW_PWM_STEPS))
`define LSW_PWM_MAX_HZ      1000
`define LSW_MIN_TICK_CYC    ((`LSW_CLK_HZ + `LSW_PWM_MAX_HZ * `LSW_PWM_STEPS - 1) / (`LSW_PWM_MAX_HZ * `LSW_PWM_STEPS))
`define LSW_DIV_W           13

// ----------------------------------------------------------------------------
// Clock-fail thresholds on the external reference
// ----------------------------------------------------------------------------
`define LSW_FAIL_LOW_HZ     2000
`define LSW_FAIL_HIGH_HZ    200000
`define LSW_FAIL_LOW_CYC    (`LSW_CLK_HZ / `LSW_FAIL_LOW_HZ)
`define LSW_FAIL_HIGH_CYC   (`LSW_CLK_HZ / `LSW_FAIL_HIGH_HZ)
`define LSW_GAP_W           14

// ----------------------------------------------------------------------------
// Calibration pulse window and input toggle timeout
// ----------------------------------------------------------------------------
`define LSW_CAL_MIN_US      20
`define LSW_CAL_MAX_US      200
`define LSW_CAL_MIN_CYC     (`LSW_CAL_MIN_US * `LSW_CLK_MHZ)
`define LSW_CAL_MAX_CYC     (`LSW_CAL_MAX_US * `LSW_CLK_MHZ)
`define LSW_TOGGLE_MS       250
`define LSW_TOGGLE_CYC      (`LSW_TOGGLE_MS * `LSW_CLK_MHZ * 1000)
`define LSW_TOG_W           23

`endif

// >>> lsw_pkg.sv
/*
 * Types shared by the lamp switch control modules.
 * Assumes nothing of its surroundings.
 */
package lsw_pkg;
   // Calibration pulse measurement states
   typedef enum {LSW_CAL_IDLE, LSW_CAL_LOW} lsw_cal_state_t;
   // Sense source: 0..3 output current, 4 board temperature
   typedef logic [2:0] lsw_sense_t;
   // Duty cycle, 8'hFF holds the output fully on
   typedef logic [7:0] lsw_duty_t;
endpackage

// >>> lsw_clkmon_if.sv
/*
 * Carrier between the control core and the clock-fail monitor.
 * Assumes both ends run on ref_clk.
 */
`timescale 1ns/100ps
`default_nettype none
interface lsw_clkmon_if;
   logic enable;   // Monitoring allowed
   logic edge_p;   // Rising edge of the external reference
   logic fail_p;   // One-cycle failure pulse
   modport mon (input enable, input edge_p, output fail_p);
   modport ctl (output enable, output edge_p, input fail_p);
endinterface
`default_nettype wire

// >>> lsw_clk_monitor.sv
/*
 * Clock-fail monitor: measures the gap between reference edges.
 * Assumes edge_p is already synchronised to ref_clk.
 */
`include "lsw_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module lsw_clk_monitor #(
   parameter int unsigned LOW_CYC = `LSW_FAIL_LOW_CYC
) (
   input  wire logic ref_clk,
   input  wire logic nrst,
   lsw_clkmon_if.mon mon
);
   localparam logic [`LSW_GAP_W-1:0] HIGH_LIM = `LSW_GAP_W'(`LSW_FAIL_HIGH_CYC);
   localparam logic [`LSW_GAP_W-1:0] LOW_LIM  = `LSW_GAP_W'(LOW_CYC);

   logic [`LSW_GAP_W-1:0] gap_q;
   logic                  armed_q;
   logic                  stalled_q;
   logic                  fail_q;

   // ---------------------------------------------------------------------
   // Gap counter
   // ---------------------------------------------------------------------
   // First edge after enable only arms; no period is known before it
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         gap_q     <= '0;
         armed_q   <= 1'b0;
         stalled_q <= 1'b0;
      end else if (!mon.enable) begin
         gap_q     <= '0;
         armed_q   <= 1'b0;
         stalled_q <= 1'b0;
      end else if (mon.edge_p) begin
         gap_q     <= '0;
         armed_q   <= 1'b1;
         stalled_q <= 1'b0;
      end else if (gap_q == LOW_LIM) begin
         stalled_q <= 1'b1;                     // Report a stopped clock once
      end else begin
         gap_q <= gap_q + 1'b1;
      end
   end

   // ---------------------------------------------------------------------
   // Failure pulse
   // ---------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         fail_q <= 1'b0;
      end else begin
         fail_q <= mon.enable &
                   ((mon.edge_p & armed_q & (gap_q < HIGH_LIM)) |
                    (!mon.edge_p & (gap_q == LOW_LIM) & !stalled_q));
      end
   end
   assign mon.fail_p = fail_q;

   // ---------------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------------
   property p_too_fast;
      @(posedge ref_clk) disable iff (!nrst)
      mon.enable && mon.edge_p && armed_q && gap_q < HIGH_LIM |=> mon.fail_p;
   endproperty
   a_too_fast: assert property (p_too_fast) else $error("fast reference not flagged");

   property p_too_slow;
      @(posedge ref_clk) disable iff (!nrst)
      mon.enable && !mon.edge_p && gap_q == LOW_LIM && !stalled_q |=> mon.fail_p;
   endproperty
   a_too_slow: assert property (p_too_slow) else $error("slow reference not flagged");

   property p_gated;
      @(posedge ref_clk) disable iff (!nrst)
      mon.fail_p |-> $past(mon.enable);
   endproperty
   a_gated: assert property (p_gated) else $error("failure flagged while disabled");
endmodule
`default_nettype wire

// >>> lsw_mcu_model.sv
/* Microcontroller model: drives the four direct input pins and chip select.
   Assumes the bench calls its tasks; ref_clk times level changes and chip-select pulses. */
`timescale 1ns/100ps
`default_nettype none
module lsw_mcu_model (
   input  wire logic       ref_clk,
   output var  logic [3:0] din,
   output var  logic       cs_n,
   output var  logic [3:0] ctl
);
   // Pins idle low, chip select idle high; internal source selected
   initial begin
      din  = 4'h0;
      cs_n = 1'b1;
      ctl  = 4'b0010;
   end
   // Control bits: 0 PWM enable, 1 source select, 2 fail-safe, 3 fail clear
   task automatic set_ctl(input int idx, input logic v);
      ctl[idx] = v;
   endtask
   // Levels change on the falling edge, away from sampling
   task automatic set_din(input logic [3:0] v);
      @(negedge ref_clk) din = v;
   endtask
   // Reference on input zero, free of the bench clock phase, low between bursts
   task automatic ref_burst(input int half_ns, input int edges);
      repeat (edges) begin
         #(half_ns) din[0] = 1'b1;
         #(half_ns) din[0] = 1'b0;
      end
   endtask
   // Chip-select low pulse of cyc clock cycles
   task automatic cal_pulse(input int cyc);
      @(negedge ref_clk) cs_n = 1'b0;
      repeat (cyc) @(negedge ref_clk);
      cs_n = 1'b1;
   endtask
endmodule
`default_nettype wire

// >>> lamp_switch_pwm_input_control_bench.sv
/* Bench: one task per scenario against lsw_ctrl with shortened counts.
   Assumes the MCU model owns pins; long PWM periods are not run out. */
`timescale 1ns/100ps
`default_nettype none
module lamp_switch_pwm_input_control_bench;
   logic                     ref_clk, nrst, sense_hiz;
   logic [3:0]               channel_direct_en, din, hs, ctl;
   logic                     cs_n, clock_fail, calibrated, wake, input_toggle_timeout, sense_output_en;
   lsw_pkg::lsw_duty_t [3:0] duty_cycle;
   lsw_pkg::lsw_sense_t      sense_select, sense_source;
   int                       miscompares, n_checks, cycles, bad;
   lsw_mcu_model i_lsw_mcu_model (.ref_clk(ref_clk), .din(din), .cs_n(cs_n), .ctl(ctl));
   lsw_ctrl #(.CAL_MAX_CYC(600), .TOGGLE_CYC(200)) i_lsw_ctrl (
      .ref_clk(ref_clk), .nrst(nrst), .direct_input_zero(din[0]), .direct_input_one(din[1]),
      .direct_input_two(din[2]), .direct_input_three(din[3]), .chip_select_n(cs_n), .pwm_enable(ctl[0]),
      .clock_source_sel(ctl[1]), .fail_safe(ctl[2]), .channel_direct_en(channel_direct_en),
      .duty_cycle(duty_cycle), .sense_select(sense_select), .sense_hiz(sense_hiz),
      .clock_fail_clear(ctl[3]), .high_side_output_zero(hs[0]), .high_side_output_one(hs[1]),
      .high_side_output_two(hs[2]), .high_side_output_three(hs[3]), .clock_fail(clock_fail),
      .calibrated(calibrated), .wake(wake), .input_toggle_timeout(input_toggle_timeout),
      .sense_source(sense_source), .sense_output_en(sense_output_en));
   // Clock and hang guard; the ceiling is nearly twice the scenario total
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 40000) begin
         miscompares++;
         conclude();
      end
   end
   task automatic chk(input logic ok, input string m);
      n_checks++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   task automatic conclude();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic t_direct_and_fail_safe();
      i_lsw_mcu_model.set_din(4'b1010);
      repeat (4) @(negedge ref_clk);
      chk(hs === 4'b1010 && wake === 1'b1, "direct drive or wake");
      i_lsw_mcu_model.set_ctl(2, 1'b1);
      channel_direct_en = 4'h0;
      i_lsw_mcu_model.set_din(4'b0110);
      repeat (4) @(negedge ref_clk);
      chk(hs === 4'b0110 && sense_source === 3'h0 && sense_output_en === 1'b0, "fail-safe");
      i_lsw_mcu_model.set_ctl(2, 1'b0);
   endtask
   task automatic t_sense();
      sense_hiz = 1'b0;
      sense_select = 3'h4;
      repeat (3) @(negedge ref_clk);
      chk(sense_source === 3'h4 && sense_output_en === 1'b1, "temperature sense");
      sense_select = 3'h2;
      sense_hiz = 1'b1;
      repeat (3) @(negedge ref_clk);
      chk(sense_source === 3'h2 && sense_output_en === 1'b0, "sense release");
   endtask
   task automatic t_duty();
      i_lsw_mcu_model.set_ctl(0, 1'b1);
      duty_cycle = {8'h00, 8'h00, 8'hFF, 8'hFF};
      repeat (5) @(negedge ref_clk);
      bad = 0;
      repeat (2000) @(negedge ref_clk) if (hs[1] !== 1'b1 || hs[2] !== 1'b0) bad++;
      chk(bad == 0, "full on or full off duty");
   endtask
   task automatic t_clock_fail();
      i_lsw_mcu_model.ref_burst(160, 20);
      chk(clock_fail === 1'b0, "monitor active on internal source");
      i_lsw_mcu_model.set_ctl(1, 1'b0);
      // 25 kHz reference, inside the legal band
      i_lsw_mcu_model.ref_burst(20000, 5);
      chk(clock_fail === 1'b0, "in-range reference flagged");
      i_lsw_mcu_model.ref_burst(160, 10);
      repeat (5) @(negedge ref_clk);
      chk(clock_fail === 1'b1, "fast reference not flagged");
      i_lsw_mcu_model.set_ctl(3, 1'b1);
      @(negedge ref_clk);
      i_lsw_mcu_model.set_ctl(3, 1'b0);
      repeat (3) @(negedge ref_clk);
      chk(clock_fail === 1'b0, "flag not cleared");
      repeat (12600) @(negedge ref_clk);
      chk(clock_fail === 1'b1, "stopped reference not flagged");
      i_lsw_mcu_model.set_ctl(1, 1'b1);
   endtask
   task automatic t_calibrate();
      // Window ends: 499 and 601 cycles refused, 500 cycles (20 us) taken
      i_lsw_mcu_model.cal_pulse(499);
      i_lsw_mcu_model.cal_pulse(601);
      repeat (5) @(negedge ref_clk);
      chk(calibrated === 1'b0, "out-of-window pulse taken");
      i_lsw_mcu_model.cal_pulse(500);
      repeat (5) @(negedge ref_clk);
      chk(calibrated === 1'b1, "in-window pulse refused");
   endtask
   task automatic t_toggle();
      i_lsw_mcu_model.set_din(4'b0001);
      repeat (150) @(negedge ref_clk);
      chk(input_toggle_timeout === 1'b0, "early timeout");
      repeat (60) @(negedge ref_clk);
      chk(input_toggle_timeout === 1'b1, "no timeout");
   endtask
   // Reset held three cycles, outputs checked while it is low
   initial begin
      {nrst, sense_select} = '0;
      {sense_hiz, channel_direct_en, duty_cycle} = {1'b1, 4'hF, 32'h0};
      repeat (3) @(negedge ref_clk);
      chk(hs === 4'h0 && clock_fail === 1'b0 && sense_output_en === 1'b0, "reset values");
      nrst = 1'b1;
      t_direct_and_fail_safe();
      t_sense();
      t_duty();
      t_clock_fail();
      t_calibrate();
      t_toggle();
      conclude();
   end
endmodule
`default_nettype wire
